//--- clbi_pkg.sv
package clbi_pkg;
  // Bus state encoding, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_PIPE = 5'h08,
    ST_HELD = 5'h10
  } clbi_state_t;

  // Lane layout
  localparam int          LANE_W      = 8;
  localparam int          LANES       = 4;
  localparam int          ADDR_W      = 30;
  localparam int          DATA_W      = 32;
  localparam int          HALF_W      = 16;
  // Reset values and constants
  localparam logic [3:0]  BE_NONE     = 4'hf;
  localparam logic [3:0]  BE_UPPER    = 4'hc;
  localparam logic [3:0]  BE_LOWER    = 4'h3;
  localparam logic [1:0]  SIZE_DWORD  = 2'h3;
  localparam logic [29:0] ADDR_RST    = 30'h00000000;
  // Coprocessor port window, word address form
  localparam logic [29:0] COPRO_WORD0 = 30'h2000003e;
  localparam logic [29:0] COPRO_WORD1 = 30'h2000003f;
  localparam logic [15:0] PORT_MASK   = 16'hffff;
endpackage

//--- clbi_core.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] 32-bit data, 30 address bits, four enables
// [RULE_02] Narrow bus: issue extra 16-bit cycle
// [RULE_03] Pipelining: drive next address before acknowledge; code drives the next address only after the acknowledge
// [RULE_04] Pipelining chosen per bus cycle; code never reads I_NEXT_ADDR_N and never pipelines
// [RULE_05] Cycle lasts two periods, extended until acknowledge
// [RULE_06] When held, only hold acknowledge driven
// [RULE_07] Trailing-n signals are active low
// [RULE_08] Input clock halved into two phases
// [RULE_09] Reset falling edge aligns clock phase
// [RULE_10] Partner drives valid data at read end
// [RULE_11] Writes drive all 32 data lines
// [RULE_12] 4 GB memory, 64 KB port space
// [RULE_13] Coprocessor ports 800000F8H to 800000FFH
// [RULE_14] Enable n qualifies byte lane n
// [RULE_15] Asserted enable count equals operand size
// [RULE_16] Upper-half writes copied to lower lanes
// [RULE_17] Acknowledge ignored in first state
// [RULE_18] Address strobe asserted in first and pipelined; code strobes only in the first ST_DATA state, ST_PIPE is never entered
module clbi_core (
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Internal request side
  input  wire logic        I_REQ_VALID,
  input  wire logic        I_REQ_WRITE,
  input  wire logic        I_REQ_MEM,
  input  wire logic        I_REQ_DATA,
  input  wire logic [29:0] I_REQ_ADDR,
  input  wire logic [3:0]  I_REQ_BE,
  input  wire logic [31:0] I_REQ_WDATA,
  output logic             O_REQ_READY,
  output logic             O_DONE,
  output logic [31:0]      O_RDATA,
  output logic             O_PHASE2,
  // Local bus side
  input  wire logic        I_READY_N,
  input  wire logic        I_NEXT_ADDR_N,
  input  wire logic        I_NARROW_WIDTH_SELECT_N,
  input  wire logic        I_HOLD,
  output logic             O_HOLD_ACKNOWLEDGE,
  output logic             O_ADDRESS_STROBE_N,
  output logic [29:0]      O_WORD_ADDRESS_BITS,
  output logic [3:0]       O_BYTE_LANE_ENABLES_N,
  output logic             O_WRITE_READ_N,
  output logic             O_MEM_IO_N,
  output logic             O_DATA_CTRL_N,
  output logic             O_BUS_OE,
  input  wire logic [31:0] I_DATA,
  output logic [31:0]      O_DATA,
  output logic             O_DATA_OE,
  output logic             O_COPRO_CYCLE
);
  clbi_pkg::clbi_state_t state_q;
  logic        phase_q;
  logic        first_q;
  logic        pend_q;
  logic        pend_wr_q;
  logic        pend_mem_q;
  logic        pend_dc_q;
  logic [29:0] pend_addr_q;
  logic [3:0]  pend_be_q;
  logic [31:0] pend_wd_q;
  logic        cur_wr_q;
  logic [3:0]  cur_be_q;
  logic [31:0] cur_wd_q;
  logic [31:0] rd_q;
  logic        second_half_q;
  logic        ack;
  logic        need_second;
  logic [3:0]  lo_be;
  logic [3:0]  hi_be;
  logic [31:0] wd_dup;

  // Acknowledge sampled only after the first state
  assign ack = !I_READY_N && !first_q && phase_q; // [RULE_17] [RULE_05] [RULE_07]
  assign lo_be = cur_be_q & clbi_pkg::BE_LOWER; // [RULE_14]
  assign hi_be = cur_be_q & clbi_pkg::BE_UPPER;
  // Narrow bus with both halves active needs an upper half cycle
  assign need_second = !I_NARROW_WIDTH_SELECT_N && !second_half_q
                       && (lo_be != 4'h0) && (hi_be != 4'h0); // [RULE_02]

  // Upper-only write data copied onto lower lanes
  always_comb
  begin
    wd_dup = cur_wd_q;
    if (cur_be_q[3:2] != 2'h0 && cur_be_q[1:0] == 2'h0) // [RULE_16]
    begin
      wd_dup[clbi_pkg::HALF_W-1:0] = cur_wd_q[clbi_pkg::DATA_W-1:clbi_pkg::HALF_W];
    end
  end

  // Internal two-phase clock from the double-rate input
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      phase_q <= 1'b0; // [RULE_09]
    else
      phase_q <= ~phase_q; // [RULE_08]
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      O_PHASE2 <= 1'b0;
    else
      O_PHASE2 <= ~phase_q;
  end

  // Pending request latch, taken when the slot is empty and O_REQ_READY is high
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pend_q      <= 1'b0;
      pend_wr_q   <= 1'b0;
      pend_mem_q  <= 1'b0;
      pend_dc_q   <= 1'b0;
      pend_addr_q <= clbi_pkg::ADDR_RST;
      pend_be_q   <= clbi_pkg::BE_NONE;
      pend_wd_q   <= '0;
      O_REQ_READY <= 1'b0;
    end
    else
    begin
      O_REQ_READY <= !pend_q && !(I_REQ_VALID && O_REQ_READY);
      if (I_REQ_VALID && O_REQ_READY && !pend_q)
      begin
        pend_q      <= 1'b1;
        pend_wr_q   <= I_REQ_WRITE;
        pend_mem_q  <= I_REQ_MEM;
        pend_dc_q   <= I_REQ_DATA;
        // Port cycles use only the low 14 word address bits and address bit 29
        pend_addr_q <= I_REQ_MEM ? I_REQ_ADDR
                       : (I_REQ_ADDR & {16'h0000, clbi_pkg::PORT_MASK[15:2]}) |
                         {I_REQ_ADDR[29], 29'h0}; // [RULE_12] [RULE_13]
        pend_be_q   <= I_REQ_BE; // [RULE_15]
        pend_wd_q   <= I_REQ_WDATA;
      end
      // Freed only when the state machine really starts the pending cycle
      else if (phase_q && pend_q && !I_HOLD
               && (state_q == clbi_pkg::ST_IDLE
               || ((state_q == clbi_pkg::ST_DATA || state_q == clbi_pkg::ST_PIPE)
               && ack && !need_second)))
        pend_q <= 1'b0; // [RULE_03]
    end
  end

  // Bus state machine
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q       <= clbi_pkg::ST_IDLE;
      first_q       <= 1'b0;
      second_half_q <= 1'b0;
      cur_wr_q      <= 1'b0;
      cur_be_q      <= clbi_pkg::BE_NONE;
      cur_wd_q      <= '0;
      rd_q          <= '0;
      O_DONE        <= 1'b0;
    end
    else
    begin
      O_DONE <= 1'b0;
      if (phase_q)
      begin
        case (state_q)
          clbi_pkg::ST_IDLE:
          begin
            if (I_HOLD)
              state_q <= clbi_pkg::ST_HELD; // [RULE_06]
            else if (pend_q)
            begin
              state_q  <= clbi_pkg::ST_DATA;
              first_q  <= 1'b1;
              cur_wr_q <= pend_wr_q;
              cur_be_q <= pend_be_q;
              cur_wd_q <= pend_wd_q;
            end
          end
          clbi_pkg::ST_DATA, clbi_pkg::ST_PIPE:
          begin
            first_q <= 1'b0;
            if (ack)
            begin
              for (int i = 0; i < clbi_pkg::LANES; i++)
                if (cur_be_q[i])
                  rd_q[i*clbi_pkg::LANE_W +: clbi_pkg::LANE_W] <=
                    I_DATA[(I_NARROW_WIDTH_SELECT_N ? i : i % (clbi_pkg::LANES / 2))
                           * clbi_pkg::LANE_W +: clbi_pkg::LANE_W]; // [RULE_10] [RULE_02]
              if (need_second)
              begin
                second_half_q <= 1'b1; // [RULE_02]
                cur_be_q      <= hi_be;
                first_q       <= 1'b1;
              end
              else
              begin
                second_half_q <= 1'b0;
                O_DONE        <= 1'b1;
                if (pend_q && !I_HOLD)
                begin
                  state_q  <= clbi_pkg::ST_DATA; // [RULE_03] [RULE_04]
                  first_q  <= 1'b1;
                  cur_wr_q <= pend_wr_q;
                  cur_be_q <= pend_be_q;
                  cur_wd_q <= pend_wd_q;
                end
                else
                  state_q <= clbi_pkg::ST_IDLE;
              end
            end
          end
          clbi_pkg::ST_HELD:
            if (!I_HOLD)
              state_q <= clbi_pkg::ST_IDLE;
          default:
            state_q <= clbi_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      O_RDATA <= '0;
    else if (O_DONE)
      O_RDATA <= rd_q;
  end

  // Pin drive: address, strobe, enables, data, hold acknowledge
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_HOLD_ACKNOWLEDGE    <= 1'b0;
      O_ADDRESS_STROBE_N    <= 1'b1;
      O_WORD_ADDRESS_BITS   <= clbi_pkg::ADDR_RST;
      O_BYTE_LANE_ENABLES_N <= clbi_pkg::BE_NONE;
      O_WRITE_READ_N        <= 1'b0;
      O_MEM_IO_N            <= 1'b0;
      O_DATA_CTRL_N         <= 1'b0;
      O_BUS_OE              <= 1'b0;
      O_DATA                <= '0;
      O_DATA_OE             <= 1'b0;
      O_COPRO_CYCLE         <= 1'b0;
    end
    else
    begin
      O_HOLD_ACKNOWLEDGE <= (state_q == clbi_pkg::ST_HELD); // [RULE_06]
      O_BUS_OE           <= (state_q != clbi_pkg::ST_HELD); // [RULE_06]
      // Strobe during the first state of each cycle
      O_ADDRESS_STROBE_N <= !(state_q == clbi_pkg::ST_DATA && first_q); // [RULE_18] [RULE_07]
      O_BYTE_LANE_ENABLES_N <= ~cur_be_q; // [RULE_01] [RULE_14] [RULE_15]
      // Second half keeps its address; the pending slot may hold the next request
      if (state_q == clbi_pkg::ST_DATA && first_q && !second_half_q)
      begin
        O_WORD_ADDRESS_BITS <= pend_addr_q; // [RULE_01]
        O_WRITE_READ_N      <= cur_wr_q;
        O_MEM_IO_N          <= pend_mem_q;
        O_DATA_CTRL_N       <= pend_dc_q;
        O_COPRO_CYCLE       <= !pend_mem_q && (pend_addr_q == clbi_pkg::COPRO_WORD0
                               || pend_addr_q == clbi_pkg::COPRO_WORD1); // [RULE_13]
      end
      O_DATA    <= second_half_q ? {cur_wd_q[31:16], cur_wd_q[31:16]} : wd_dup; // [RULE_16]
      O_DATA_OE <= cur_wr_q && state_q == clbi_pkg::ST_DATA; // [RULE_11]
    end
  end
endmodule

//--- clbi_core_sva.sv
`timescale 1ns/1ps
module clbi_core_sva (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_READY_N,
  input wire logic        O_DONE,
  input wire logic        O_PHASE2,
  input wire logic        O_HOLD_ACKNOWLEDGE,
  input wire logic        O_BUS_OE,
  input wire logic        O_DATA_OE,
  input wire logic        O_ADDRESS_STROBE_N,
  input wire logic        O_WRITE_READ_N,
  input wire logic        O_MEM_IO_N,
  input wire logic        O_COPRO_CYCLE,
  input wire logic [3:0]  O_BYTE_LANE_ENABLES_N,
  input wire logic [29:0] O_WORD_ADDRESS_BITS,
  input wire logic [31:0] O_DATA
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Pin ownership, strobe qualification and upper lane copy
  a_hold_float: assert property (O_HOLD_ACKNOWLEDGE |-> !O_BUS_OE && !O_DATA_OE)
    else $error("outputs driven in hold");
  a_write_drive: assert property (!O_ADDRESS_STROBE_N && O_WRITE_READ_N |-> ##[0:3] O_DATA_OE)
    else $error("write data not driven");
  a_read_float: assert property (O_DATA_OE |-> O_WRITE_READ_N)
    else $error("data driven in read");
  a_strobe_valid: assert property (!O_ADDRESS_STROBE_N |-> O_BUS_OE && !(&O_BYTE_LANE_ENABLES_N))
    else $error("strobe without valid address");
  a_dup_lanes: assert property (O_DATA_OE && O_WRITE_READ_N && &O_BYTE_LANE_ENABLES_N[1:0]
    |-> (O_BYTE_LANE_ENABLES_N[2] || O_DATA[7:0] == O_DATA[23:16])
    && (O_BYTE_LANE_ENABLES_N[3] || O_DATA[15:8] == O_DATA[31:24])) else $error("no lane copy");
  // Cycle length, completion, coprocessor flag and phase alternation
  a_min_cycle: assert property ($fell(O_ADDRESS_STROBE_N) |-> !O_DONE [*2])
    else $error("cycle too short");
  a_done_ack: assert property (O_DONE |-> !$past(I_READY_N) || !$past(I_READY_N, 2)
    || !$past(I_READY_N, 3)) else $error("done without acknowledge");
  a_copro_flag: assert property (!O_ADDRESS_STROBE_N && !O_MEM_IO_N
    && O_WORD_ADDRESS_BITS[29:1] == clbi_pkg::COPRO_WORD0[29:1] |-> O_COPRO_CYCLE)
    else $error("coprocessor cycle not flagged");
  a_phase_toggle: assert property (!$past(I_RST) |-> O_PHASE2 != $past(O_PHASE2))
    else $error("phase not alternating");
  c_done: cover property (O_DONE && O_WRITE_READ_N);
  c_hold: cover property (O_HOLD_ACKNOWLEDGE);
  c_copro: cover property (O_COPRO_CYCLE);
endmodule

bind clbi_core clbi_core_sva clbi_core_sva_inst (.I_CLK, .I_RST, .I_READY_N, .O_DONE, .O_PHASE2,
  .O_HOLD_ACKNOWLEDGE, .O_BUS_OE, .O_DATA_OE, .O_ADDRESS_STROBE_N, .O_WRITE_READ_N, .O_MEM_IO_N,
  .O_COPRO_CYCLE, .O_BYTE_LANE_ENABLES_N, .O_WORD_ADDRESS_BITS, .O_DATA);

//--- clbi_far_model.sv
`timescale 1ns/1ps
module clbi_far_model (
  input  wire logic        i_clk,
  input  wire logic        i_ads_n,
  input  wire logic        i_done,
  input  wire logic [3:0]  i_be_n,
  input  wire logic [3:0]  i_wait,
  input  wire logic [31:0] i_rd_val,
  output logic             o_ready_n,
  output logic [31:0]      o_data
);
  logic       open_q = 1'b0;
  logic [3:0] cnt_q  = 4'h0;
  initial o_ready_n = 1'b1;
  // Acknowledge after the wait count, held until the cycle ends
  always @(negedge i_clk)
  begin
    if (!i_ads_n) open_q <= 1'b1;
    else if (i_done) open_q <= 1'b0;
    if (!i_ads_n) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    o_ready_n <= !(open_q && cnt_q >= i_wait && !i_done);
  end
  // Valid read data at acknowledge, upper half also on low lanes when both low enables are off
  assign o_data = o_ready_n ? ~i_rd_val : (&i_be_n[1:0] ? {2{i_rd_val[31:16]}} : i_rd_val);
endmodule

//--- test_cpu_local_bus_interface.sv
`timescale 1ns/1ps
module test_cpu_local_bus_interface;
  logic        I_CLK, I_RST, I_REQ_VALID, I_REQ_WRITE, I_REQ_MEM, I_REQ_DATA, I_HOLD;
  logic        I_READY_N, I_NEXT_ADDR_N, I_NARROW_WIDTH_SELECT_N, O_REQ_READY, O_DONE, O_PHASE2;
  logic        O_HOLD_ACKNOWLEDGE, O_ADDRESS_STROBE_N, O_WRITE_READ_N, O_MEM_IO_N, O_DATA_CTRL_N;
  logic        O_BUS_OE, O_DATA_OE, O_COPRO_CYCLE, seen_cp, ads_q;
  logic [29:0] I_REQ_ADDR, O_WORD_ADDRESS_BITS, seen_a;
  logic [2:0]  seen_def;
  logic [3:0]  I_REQ_BE, O_BYTE_LANE_ENABLES_N, wait_c, seen_be;
  logic [31:0] I_REQ_WDATA, I_DATA, O_DATA, O_RDATA, rd_val, seen_d, far_d;
  int          err_count, compares, ads_cnt, done_cnt;
  clbi_core clbi_core_inst (.I_CLK, .I_RST, .I_REQ_VALID, .I_REQ_WRITE, .I_REQ_MEM, .I_REQ_DATA,
    .I_REQ_ADDR, .I_REQ_BE, .I_REQ_WDATA, .O_REQ_READY, .O_DONE, .O_RDATA, .O_PHASE2, .I_READY_N,
    .I_NEXT_ADDR_N, .I_NARROW_WIDTH_SELECT_N, .I_HOLD, .O_HOLD_ACKNOWLEDGE, .O_ADDRESS_STROBE_N,
    .O_WORD_ADDRESS_BITS, .O_BYTE_LANE_ENABLES_N, .O_WRITE_READ_N, .O_MEM_IO_N, .O_DATA_CTRL_N,
    .O_BUS_OE, .I_DATA, .O_DATA, .O_DATA_OE, .O_COPRO_CYCLE);
  clbi_far_model clbi_far_model_inst (.i_clk(I_CLK), .i_ads_n(O_ADDRESS_STROBE_N), .i_done(O_DONE),
    .i_be_n(O_BYTE_LANE_ENABLES_N), .i_wait(wait_c), .i_rd_val(rd_val), .o_ready_n(I_READY_N),
    .o_data(far_d));
  // Data wire level from both drivers
  assign I_DATA = O_DATA_OE ? O_DATA : far_d;
  // Clock at 25 MHz
  initial
  begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  // Wire capture of strobes, enables, data and completions
  always @(negedge I_CLK)
  begin
    ads_q <= O_ADDRESS_STROBE_N;
    if (ads_q && !O_ADDRESS_STROBE_N) ads_cnt <= ads_cnt + 1;
    if (!O_ADDRESS_STROBE_N) {seen_be, seen_cp} <= {O_BYTE_LANE_ENABLES_N, seen_cp | O_COPRO_CYCLE};
    if (!O_ADDRESS_STROBE_N)
      {seen_a, seen_def} <= {O_WORD_ADDRESS_BITS, O_WRITE_READ_N, O_DATA_CTRL_N, O_MEM_IO_N};
    if (!I_READY_N && O_DATA_OE) seen_d <= O_DATA;
    if (O_DONE) done_cnt <= done_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    err_count++;
    $display("[ERR] wait expected event seen timeout");
    final_report();
  endtask
  task automatic send(input logic w, m, input logic [29:0] a, input logic [3:0] be,
                      input logic [31:0] d);
    int n;
    @(negedge I_CLK);
    {I_REQ_VALID, I_REQ_WRITE, I_REQ_MEM, I_REQ_ADDR, I_REQ_BE, I_REQ_WDATA} = {1'b1, w, m, a, be, d};
    for (n = 0; n < 50 && O_REQ_READY !== 1'b1; n++) @(negedge I_CLK);
    if (n == 50) timeout();
    @(negedge I_CLK);
    I_REQ_VALID = 1'b0;
  endtask
  task automatic wait_dn(input int t);
    int n;
    for (n = 0; n < 300 && done_cnt < t; n++) @(negedge I_CLK);
    if (n == 300) timeout();
  endtask
  task automatic req(input logic w, m, input logic [29:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int t;
    t = done_cnt + 1;
    send(w, m, a, be, d);
    wait_dn(t);
  endtask
  task automatic t_write();
    int a;
    a = ads_cnt;
    req(1'b1, 1'b1, 30'h00001234, 4'hf, 32'h11223344);
    chk("wire data", 32'h11223344, seen_d);
    chk("enables", 32'h0, {28'h0, seen_be});
    chk("strobes", 32'h1, ads_cnt - a);
    chk("address", 32'h00001234, {2'h0, seen_a});
    chk("definition", 32'h7, {29'h0, seen_def});
    req(1'b1, 1'b1, 30'h00001235, 4'hc, 32'haabbccdd);
    chk("upper copy", 32'haabbaabb, seen_d);
    req(1'b1, 1'b1, 30'h00001236, 4'h8, 32'h55000000);
    chk("lane three copy", 32'h55, {24'h0, seen_d[15:8]});
  endtask
  task automatic t_read_narrow();
    int a;
    a = ads_cnt;
    {I_NARROW_WIDTH_SELECT_N, wait_c, rd_val} = {1'b0, 4'h5, 32'hcafe0123};
    req(1'b0, 1'b1, 30'h00000040, 4'hf, 32'h0);
    chk("read data", 32'hcafe0123, O_RDATA);
    chk("strobes", 32'h2, ads_cnt - a);
    chk("second enables", 32'h3, {28'h0, seen_be});
    I_NARROW_WIDTH_SELECT_N = 1'b1;
  endtask
  task automatic t_pipe();
    int a;
    int t;
    a = ads_cnt;
    t = done_cnt + 2;
    {I_NEXT_ADDR_N, wait_c} = {1'b0, 4'h2};
    send(1'b1, 1'b1, 30'h00000100, 4'hf, 32'h0a0b0c0d);
    send(1'b1, 1'b1, 30'h00000101, 4'hf, 32'h1a1b1c1d);
    wait_dn(t);
    chk("last data", 32'h1a1b1c1d, seen_d);
    chk("strobes", 32'h2, ads_cnt - a);
    I_NEXT_ADDR_N = 1'b1;
  endtask
  task automatic t_copro();
    seen_cp = 1'b0;
    req(1'b0, 1'b0, clbi_pkg::COPRO_WORD1, 4'hf, 32'h0);
    chk("coproc flag", 32'h1, {31'h0, seen_cp});
    chk("coproc address", {2'h0, clbi_pkg::COPRO_WORD1}, {2'h0, seen_a});
    chk("port definition", 32'h2, {29'h0, seen_def});
    seen_cp = 1'b0;
    req(1'b0, 1'b0, 30'h0abc3ffe, 4'hf, 32'h0);
    chk("port flag", 32'h0, {31'h0, seen_cp});
    chk("port address", 32'h00003ffe, {2'h0, seen_a});
  endtask
  task automatic t_hold();
    int n;
    I_HOLD = 1'b1;
    for (n = 0; n < 50 && O_HOLD_ACKNOWLEDGE !== 1'b1; n++) @(negedge I_CLK);
    if (n == 50) timeout();
    chk("bus enable", 32'h0, {31'h0, O_BUS_OE});
    chk("data enable", 32'h0, {31'h0, O_DATA_OE});
    I_HOLD = 1'b0;
    for (n = 0; n < 50 && O_HOLD_ACKNOWLEDGE !== 1'b0; n++) @(negedge I_CLK);
    if (n == 50) timeout();
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    {I_RST, I_REQ_VALID, I_REQ_WRITE, I_REQ_MEM, I_REQ_DATA, I_HOLD} = 6'h22;
    {I_REQ_ADDR, I_REQ_BE, I_REQ_WDATA, rd_val, seen_d, seen_be, seen_cp} = '0;
    {I_NEXT_ADDR_N, I_NARROW_WIDTH_SELECT_N, wait_c} = {2'h3, 4'h0};
    {err_count, compares, ads_cnt, done_cnt} = '0;
    repeat (8) @(negedge I_CLK);
    I_RST = 1'b0;
    repeat (2) @(negedge I_CLK);
    t_write();
    t_read_narrow();
    t_pipe();
    t_copro();
    t_hold();
    final_report();
  end
endmodule
